// [logic/rx_pkg.sv]
package rx_pkg;

	// ****************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ****************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_BAUD = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0C;

	// ****************************************************************
	// Field positions and widths
	// ****************************************************************
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_DS_BIT = 1;
	localparam int CTRL_LEN_LSB = 4;
	localparam int LEN_W = 4;
	localparam int BAUD_W = 12;
	localparam int STAT_COMPLETE_BIT = 0;
	localparam int STAT_FERR_BIT = 1;
	localparam int STAT_OVR_BIT = 2;
	localparam int DATA_W = 10;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CTRL_RESET = 8'h80;
	localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;

	// ****************************************************************
	// Sampling figures
	// ****************************************************************
	localparam logic [4:0] SPB_NORMAL = 5'h10;
	localparam logic [4:0] SPB_DOUBLE = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] DS_STOP_EXTRA = 5'h01;
	localparam logic [3:0] LEN_MIN = 4'h5;
	localparam logic [3:0] LEN_MAX = 4'hA;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b10,
		ST_STOP = 2'b11
	} rx_state_t;

	typedef struct packed {
		logic ferr;
		logic [DATA_W-1:0] data;
	} rx_word_t;

endpackage

// [logic/serial_rx.sv]
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module serial_rx (
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic RXD_I,
	output logic RX_PIN_OWN_O,
	output logic RX_COMPLETE_O
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic [3:0] clamp_len(input logic [3:0] l);
		if (l < rx_pkg::LEN_MIN) begin
			return rx_pkg::LEN_MIN;
		end
		if (l > rx_pkg::LEN_MAX) begin
			return rx_pkg::LEN_MAX;
		end
		return l;
	endfunction

	// ****************************************************************
	// Registers and bus decode
	// ****************************************************************
	logic [7:0] ctrl;
	logic [rx_pkg::BAUD_W-1:0] baud_div;
	logic overrun;
	logic en;
	logic ds;
	logic [3:0] len;
	logic setup_rd;
	logic access;
	logic wr_acc;
	logic mapped;
	logic pop;
	logic ovr_set;

	assign en = ctrl[rx_pkg::CTRL_EN_BIT];
	assign ds = ctrl[rx_pkg::CTRL_DS_BIT];
	assign len = clamp_len(ctrl[rx_pkg::CTRL_LEN_LSB +: rx_pkg::LEN_W]);
	assign mapped = (PADDR_I == rx_pkg::OFF_CTRL) || (PADDR_I == rx_pkg::OFF_BAUD) ||
		(PADDR_I == rx_pkg::OFF_STATUS) || (PADDR_I == rx_pkg::OFF_DATA);
	assign setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
	assign access = PSEL_I && PENABLE_I;
	assign wr_acc = access && PWRITE_I;
	assign PREADY_O = access;
	assign PSLVERR_O = access && !mapped;
	// The receiver owns the pin only while enabled.
	assign RX_PIN_OWN_O = en;

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			ctrl <= rx_pkg::CTRL_RESET;
			baud_div <= rx_pkg::BAUD_RESET;
		end else if (wr_acc && PADDR_I == rx_pkg::OFF_CTRL) begin
			ctrl <= PWDATA_I[7:0];
		end else if (wr_acc && PADDR_I == rx_pkg::OFF_BAUD) begin
			baud_div <= PWDATA_I[rx_pkg::BAUD_W-1:0];
		end
	end

	// ****************************************************************
	// Input synchroniser and sample tick
	// ****************************************************************
	logic rxd_meta;
	logic rxd_s;
	logic [rx_pkg::BAUD_W-1:0] baud_cnt;
	logic tick;

	always_ff @(posedge MCLK_I) begin
		rxd_meta <= RXD_I;
		rxd_s <= rxd_meta;
	end

	// One tick per sample: the divisor sets the 16x or 8x sample rate.
	assign tick = en && (baud_cnt == '0);

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || !en || tick) begin
			baud_cnt <= baud_div;
		end else begin
			baud_cnt <= baud_cnt - 1'b1;
		end
	end

	// ****************************************************************
	// Clock and data recovery
	// ****************************************************************
	rx_pkg::rx_state_t state;
	logic [4:0] cnt;
	logic [4:0] num;
	logic [4:0] spb;
	logic [4:0] vfirst;
	logic [4:0] stop_end;
	logic [1:0] votes;
	logic prev_smp;
	logic vote_now;
	logic bit_val;
	logic stop_bit;
	logic [3:0] bit_idx;
	logic [rx_pkg::DATA_W-1:0] shreg;
	logic frame_done;
	rx_pkg::rx_word_t done_word;

	assign spb = ds ? rx_pkg::SPB_DOUBLE : rx_pkg::SPB_NORMAL;
	assign vfirst = ds ? rx_pkg::VOTE_FIRST_DOUBLE : rx_pkg::VOTE_FIRST_NORMAL;
	// Double speed rearms one sample after the last vote of the stop bit.
	assign stop_end = ds ? vfirst + 5'h02 + rx_pkg::DS_STOP_EXTRA : vfirst + 5'h02;
	assign num = (cnt == spb) ? 5'h01 : cnt + 5'h01;
	assign vote_now = tick && (state != rx_pkg::ST_IDLE) && (num == vfirst + 5'h02);
	assign bit_val = maj3(votes[1], votes[0], rxd_s);
	assign frame_done = tick && (state == rx_pkg::ST_STOP) && (num == stop_end);

	always_comb begin
		done_word.data = shreg >> (4'hA - len);
		done_word.ferr = (num == vfirst + 5'h02) ? !bit_val : !stop_bit;
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || !en) begin
			prev_smp <= 1'b1;
		end else if (tick) begin
			prev_smp <= rxd_s;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (tick && (num == vfirst || num == vfirst + 5'h01)) begin
			votes <= {votes[0], rxd_s};
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || !en) begin
			state <= rx_pkg::ST_IDLE;
			cnt <= 5'h00;
			bit_idx <= 4'h0;
			stop_bit <= 1'b1;
		end else if (tick) begin
			case (state)
				rx_pkg::ST_IDLE: begin
					if (prev_smp && !rxd_s) begin
						state <= rx_pkg::ST_START;
						cnt <= 5'h01;
					end
				end
				rx_pkg::ST_START: begin
					cnt <= num;
					if (vote_now && bit_val) begin
						state <= rx_pkg::ST_IDLE;
					end else if (num == spb) begin
						state <= rx_pkg::ST_DATA;
						bit_idx <= 4'h0;
					end
				end
				rx_pkg::ST_DATA: begin
					cnt <= num;
					if (num == spb) begin
						if (bit_idx == len - 4'h1) begin
							state <= rx_pkg::ST_STOP;
						end else begin
							bit_idx <= bit_idx + 4'h1;
						end
					end
				end
				rx_pkg::ST_STOP: begin
					cnt <= num;
					if (vote_now) begin
						stop_bit <= bit_val;
					end
					// Only the first stop bit is looked at; the line then rearms.
					if (num == stop_end) begin
						state <= rx_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= rx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (vote_now && state == rx_pkg::ST_DATA) begin
			shreg <= {bit_val, shreg[rx_pkg::DATA_W-1:1]};
		end
	end

	// ****************************************************************
	// Shift-register hold and two-entry buffer
	// ****************************************************************
	logic pend_valid;
	rx_pkg::rx_word_t pend;
	logic push;
	logic buf_ready;
	rx_pkg::rx_word_t mem [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;

	// The pending word waits in the shift stage while the buffer is full.
	assign buf_ready = (count != 2'h2);
	assign push = pend_valid && buf_ready;
	assign pop = access && !PWRITE_I && (PADDR_I == rx_pkg::OFF_DATA) && (count != 2'h0);
	assign ovr_set = frame_done && pend_valid && !push;
	assign RX_COMPLETE_O = (count != 2'h0);

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || !en) begin
			pend_valid <= 1'b0;
		end else if (frame_done && !ovr_set) begin
			pend_valid <= 1'b1;
			pend <= done_word;
		end else if (push) begin
			pend_valid <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (push) begin
			mem[wr_ptr] <= pend;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || !en) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= !wr_ptr;
			end
			if (pop) begin
				rd_ptr <= !rd_ptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// Overrun is sticky; a new loss in the clearing cycle wins over the clear.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			overrun <= 1'b0;
		end else if (ovr_set) begin
			overrun <= 1'b1;
		end else if (wr_acc && PADDR_I == rx_pkg::OFF_STATUS &&
			PWDATA_I[rx_pkg::STAT_OVR_BIT]) begin
			overrun <= 1'b0;
		end
	end

	// ****************************************************************
	// Read data, captured in the setup cycle
	// ****************************************************************
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (setup_rd) begin
			PRDATA_O <= 32'h0000_0000;
			case (PADDR_I)
				rx_pkg::OFF_CTRL: begin
					PRDATA_O[7:0] <= ctrl;
				end
				rx_pkg::OFF_BAUD: begin
					PRDATA_O[rx_pkg::BAUD_W-1:0] <= baud_div;
				end
				rx_pkg::OFF_STATUS: begin
					PRDATA_O[rx_pkg::STAT_COMPLETE_BIT] <= (count != 2'h0);
					PRDATA_O[rx_pkg::STAT_FERR_BIT] <= (count != 2'h0) && mem[rd_ptr].ferr;
					PRDATA_O[rx_pkg::STAT_OVR_BIT] <= overrun;
				end
				rx_pkg::OFF_DATA: begin
					if (count != 2'h0) begin
						PRDATA_O[rx_pkg::DATA_W-1:0] <= mem[rd_ptr].data;
					end
				end
				default: begin
					PRDATA_O <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);

	chk_disable_abort: assert property (!en |=> state == rx_pkg::ST_IDLE && cnt == 5'h00)
		else $error("receiver not idle after disable");
	chk_pin_release: assert property ($fell(en) |=> !RX_PIN_OWN_O)
		else $error("pin still owned after disable");
	chk_disable_flush: assert property (!en |=> count == 2'h0 && !pend_valid)
		else $error("buffer not flushed on disable");
	chk_sample_range: assert property (state != rx_pkg::ST_IDLE
		|-> cnt >= 5'h01 && cnt <= spb)
		else $error("sample counter out of range");
	chk_start_detect: assert property (tick && state == rx_pkg::ST_IDLE && prev_smp
		&& !rxd_s |=> state == rx_pkg::ST_START && cnt == 5'h01)
		else $error("start edge not taken");
	chk_start_reject: assert property (vote_now && state == rx_pkg::ST_START && bit_val
		|=> state == rx_pkg::ST_IDLE)
		else $error("noisy start bit accepted");
	// The stop vote itself is the reference, so a late rearm point shows up here.
	chk_normal_rearm: assert property (vote_now && state == rx_pkg::ST_STOP && !ds
		|=> state == rx_pkg::ST_IDLE)
		else $error("normal mode rearm point wrong");
	chk_frame_len: assert property (frame_done |-> bit_idx == len - 4'h1)
		else $error("wrong number of bits in frame");
	chk_buffer_depth: assert property (count <= 2'h2)
		else $error("buffer over two entries");
	chk_complete_read: assert property (setup_rd && PADDR_I == rx_pkg::OFF_STATUS
		|=> PRDATA_O[rx_pkg::STAT_COMPLETE_BIT] == ($past(count) != 2'h0))
		else $error("complete flag disagrees with buffer");

	cov_frame: cover property (frame_done && !done_word.ferr);
	cov_ferr: cover property (frame_done && done_word.ferr);
	cov_reject: cover property (vote_now && state == rx_pkg::ST_START && bit_val);
	cov_overrun: cover property (ovr_set);
	cov_double: cover property (frame_done && ds);

endmodule

// [tb/serial_tx_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Remote asynchronous transmitter
// ****************************************************************
module serial_tx_model (
	input wire logic clk_i,
	output logic line_o
);
	initial line_o = 1'b1;

	// Each call holds one level for n clock cycles, changed just after an edge.
	task automatic hold(input logic v, input int n);
		@(posedge clk_i);
		line_o <= v;
		repeat (n - 1) @(posedge clk_i);
	endtask

	// A zero stop value models a broken frame; the line returns to idle afterwards.
	// A stop shorter than a bit lets the next start follow as early as allowed.
	task automatic send(input logic [9:0] d, input int len, input logic stop, input int bclk,
		input int sbclk);
		hold(1'b0, bclk);
		for (int i = 0; i < len; i++) begin
			hold(d[i], bclk);
		end
		hold(stop, sbclk);
		hold(1'b1, 1);
	endtask
endmodule

// [tb/uart_async_receiver_recovery_tb_top.sv]
`timescale 1ns/1ps
module uart_async_receiver_recovery_tb_top;
	localparam int BAUD = 3;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, rxd, pin_own, complete, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] d1, d2;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	int sstop;
	int ds_tab[3] = '{1, 0, 1};
	int len_tab[3] = '{5, 10, 10};

	serial_rx DUT (.MCLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .RXD_I(rxd), .RX_PIN_OWN_O(pin_own),
		.RX_COMPLETE_O(complete));
	serial_tx_model tx (.clk_i(clk), .line_o(rxd));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************************************************************
	// Verdict and hang guard
	// ****************************************************************
	task automatic end_sim();
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			end_sim();
		end
	end

	// ****************************************************************
	// Bus and compare tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task automatic frame(input logic [9:0] d, input int len, input logic stop, input int ds);
		int bclk;
		bclk = (BAUD + 1) * (ds ? 8 : 16);
		tx.send(d, len, stop, bclk, bclk);
		repeat (8) @(posedge clk);
	endtask

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc("ctrl", rx_pkg::OFF_CTRL, 32'h80);
		rdc("status", rx_pkg::OFF_STATUS, 32'h0);
		chk("pin_own", 32'h0, {31'h0, pin_own});
		xfer(1'b0, 8'h10, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		xfer(1'b1, rx_pkg::OFF_BAUD, BAUD);
		rdc("baud", rx_pkg::OFF_BAUD, BAUD);
		xfer(1'b1, rx_pkg::OFF_CTRL, 32'h81);
		#1;
		chk("pin_own", 32'h1, {31'h0, pin_own});
		frame(10'h0A5, 8, 1'b1, 0);
		frame(10'h03C, 8, 1'b0, 0);
		rdc("status", rx_pkg::OFF_STATUS, 32'h1);
		rdc("data", rx_pkg::OFF_DATA, 32'hA5);
		rdc("status", rx_pkg::OFF_STATUS, 32'h3);
		rdc("data", rx_pkg::OFF_DATA, 32'h3C);
		rdc("status", rx_pkg::OFF_STATUS, 32'h0);
		// Eight low samples leave samples nine and ten high, so the vote rejects it.
		// The line then idles for a whole frame, so a wrongly accepted start would land.
		tx.hold(1'b0, 8 * (BAUD + 1));
		tx.hold(1'b1, 11 * 16 * (BAUD + 1));
		rdc("status", rx_pkg::OFF_STATUS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			frame(10'h011 * (i + 1), 8, 1'b1, 0);
		end
		rdc("status", rx_pkg::OFF_STATUS, 32'h5);
		n = 0;
		xfer(1'b0, rx_pkg::OFF_STATUS, 32'h0);
		while (rd[0] === 1'b1 && n < 8) begin
			rdc("fifo", rx_pkg::OFF_DATA, 32'h11 * (n + 1));
			n++;
			xfer(1'b0, rx_pkg::OFF_STATUS, 32'h0);
		end
		chk("depth", 32'h3, n);
		xfer(1'b1, rx_pkg::OFF_STATUS, 32'h4);
		rdc("status", rx_pkg::OFF_STATUS, 32'h0);
		for (int m = 0; m < 3; m++) begin
			d1 = 10'h3A5 ^ m;
			d2 = 10'h25A ^ m;
			// The first stop ends one sample after its last vote, then the next start falls.
			sstop = (BAUD + 1) * (ds_tab[m] ? 7 : 11) - 1;
			xfer(1'b1, rx_pkg::OFF_CTRL, (len_tab[m] << 4) | (ds_tab[m] << 1) | 1);
			rdc("ctrl", rx_pkg::OFF_CTRL, (len_tab[m] << 4) | (ds_tab[m] << 1) | 1);
			tx.send(d1, len_tab[m], 1'b1, (BAUD + 1) * (ds_tab[m] ? 8 : 16), sstop);
			frame(d2, len_tab[m], 1'b1, ds_tab[m]);
			rdc("data", rx_pkg::OFF_DATA, d1 & ((1 << len_tab[m]) - 1));
			rdc("data", rx_pkg::OFF_DATA, d2 & ((1 << len_tab[m]) - 1));
		end
		xfer(1'b1, rx_pkg::OFF_CTRL, 32'h81);
		frame(10'h001, 8, 1'b1, 0);
		frame(10'h002, 8, 1'b1, 0);
		#1;
		chk("complete", 32'h1, {31'h0, complete});
		fork
			frame(10'h0FF, 8, 1'b1, 0);
			begin
				repeat (300) @(posedge clk);
				xfer(1'b1, rx_pkg::OFF_CTRL, 32'h80);
			end
		join
		#1;
		chk("complete", 32'h0, {31'h0, complete});
		chk("pin_own", 32'h0, {31'h0, pin_own});
		xfer(1'b1, rx_pkg::OFF_CTRL, 32'h81);
		rdc("status", rx_pkg::OFF_STATUS, 32'h0);
		frame(10'h0C3, 8, 1'b1, 0);
		rdc("data", rx_pkg::OFF_DATA, 32'hC3);
		end_sim();
	end
endmodule
